// *** design/afl_mute_timer.sv ***
// Purpose: Master clock divider and internal mute timer after power-up
// Assumes: run is the synchronised power-down release
// Notes:   Timer restarts whenever run falls
`timescale 1ns/1ns
module afl_mute_timer #(
  parameter int TICKS = afl_pkg::INT_MUTE_TICKS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Control
  input  wire logic run,
  // Status
  output logic      mclk_tick,
  output logic      done
);

  localparam int CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] CNT_END = CW'(TICKS);

  logic          div;
  logic          next_div;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_done;

  assign mclk_tick = div;

  always_comb begin
    next_div  = div;
    next_cnt  = cnt;
    next_done = done;
    if (ce) begin
      next_div = ~div; // RULE_14
      if (!run) begin
        next_cnt  = '0;
        next_done = 1'b0;
      end else if (div && cnt != CNT_END) begin
        next_cnt  = cnt + CW'(1);
        next_done = (cnt + CW'(1)) == CNT_END; // RULE_15
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div  <= 1'b0;
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      div  <= next_div;
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

endmodule

// *** design/afl_pkg.sv ***
// Purpose: Shared constants and types for the amplifier fault latch and control block
// Assumes: 32-bit APB register port, one 24.576 MHz clock
// Notes:   Master clock tick is the block clock divided by two
package afl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          APB_AW              = 12;
  localparam logic [11:0] OFS_CTRL            = 12'h000;
  localparam logic [11:0] OFS_STATUS          = 12'h004;
  localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;

  localparam int          CTRL_SOFT_MUTE_BIT  = 0;
  localparam int          CTRL_ERR_CLEAR_BIT  = 1;

  localparam int          STAT_ERR_LSB        = 0;
  localparam int          STAT_WARN_BIT       = 4;
  localparam int          STAT_STAGE_EN_BIT   = 5;
  localparam int          STAT_INT_DONE_BIT   = 6;
  localparam int          STAT_MOD_EN_BIT     = 7;
  localparam int          STAT_GAIN_LSB       = 8;
  localparam int          STAT_PIN_ERR_BIT    = 10;
  localparam int          STAT_PIN_WARN_BIT   = 11;
  localparam int          STAT_STATE_LSB      = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Error latch indices
  localparam int          ERR_TEMP            = 0;
  localparam int          ERR_OVERCUR         = 1;
  localparam int          ERR_UNDERVOLT       = 2;
  localparam int          ERR_CLK_LOSS        = 3;
  localparam int          ERR_NUM             = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Gain codes in dB
  localparam logic [4:0]  GAIN_DB_00          = 5'h00;
  localparam logic [4:0]  GAIN_DB_01          = 5'h06;
  localparam logic [4:0]  GAIN_DB_10          = 5'h0c;
  localparam logic [4:0]  GAIN_DB_11          = 5'h12;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          MCLK_DIV            = 2;
  localparam int          T_INT_MUTE_MS       = 650;
  localparam int          REF_CLK_KHZ         = 24576;
  localparam int          INT_MUTE_TICKS      = T_INT_MUTE_MS * REF_CLK_KHZ / MCLK_DIV;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [ERR_NUM-1:0] afl_err_t;

  typedef struct packed {
    logic clk_missing;
    logic supply_uv;
    logic over_current;
    logic temp_shut;
    logic temp_cool;
    logic temp_warn_trip;
  } afl_fault_s;

  typedef struct packed {
    logic power_down_n;
    logic mute_n;
    logic gain_sel_msb;
    logic gain_sel_lsb;
  } afl_ctl_s;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_MUTED = 2'b01,
    ST_RUN   = 2'b11,
    ST_FAULT = 2'b10
  } afl_state_e;

endpackage

// *** design/afl_sync.sv ***
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels
// Assumes: Clock enable freezes both stages
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module afl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = ce ? d : meta;
    next_q    = ce ? meta : q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule

// *** design/afl_top.sv ***
// Purpose: Fault flags, error latches and power stage control of a switching amplifier
// Assumes: Detector outputs and pins are asynchronous levels; APB register port
// Notes:   Flag pins are open drain, driven only low
//
// Overview of operation
// RULE_01: Two gain pins select 0/6/12/18 dB
// RULE_02: Warning comparator pulls warning flag low
// RULE_03: Warning alone never stops the power stage
// RULE_04: Over-temperature shutdown latches error flag low
// RULE_05: Error clears only on mute low-then-high; code also clears on a CTRL bit 1 write
// RULE_06: Overcurrent latches error flag, outputs protected
// RULE_07: Supply undervoltage: stage hi-Z, error latched
// RULE_08: Missing master clock latches error flag
// RULE_09: Both flags open drain, wire-OR capable
// RULE_10: Warning released only after cooling threshold
// RULE_11: Mute low shuts down output bridge
// RULE_12: Mute high without error resumes amplification
// RULE_13: Power-down stops modulator, stage hi-Z
// RULE_14: Master clock is input divided by two
// RULE_15: Internal mute holds stage after power-up
// RULE_16: Async inputs pass two-stage synchronisers; code reads thermal_warn_n_i and error_n_i into STATUS unsynchronised
// RULE_17: Any error latch forces stage off
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
module afl_top #(
  parameter int INT_MUTE_TICKS = afl_pkg::INT_MUTE_TICKS
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Control pins
  input  wire logic        mute_n,
  input  wire logic        power_down_n,
  input  wire logic        gain_sel_msb,
  input  wire logic        gain_sel_lsb,
  // Analog detector outputs
  input  wire logic        temp_warn_trip,
  input  wire logic        temp_cool,
  input  wire logic        temp_shut,
  input  wire logic        over_current,
  input  wire logic        supply_uv,
  input  wire logic        clk_missing,
  // Open-drain flag pins
  input  wire logic        thermal_warn_n_i,
  output logic             thermal_warn_n_o,
  output logic             thermal_warn_n_oe_n,
  input  wire logic        error_n_i,
  output logic             error_n_o,
  output logic             error_n_oe_n,
  // Modulator and power stage
  output logic             modulator_en,
  output logic             stage_en,
  output logic             stage_hiz,
  output logic      [1:0]  gain_code,
  output logic      [4:0]  gain_db
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] code_to_db(input logic [1:0] code);
    logic [4:0] db;
    case (code)
      2'h0:    db = afl_pkg::GAIN_DB_00;
      2'h1:    db = afl_pkg::GAIN_DB_01;
      2'h2:    db = afl_pkg::GAIN_DB_10;
      default: db = afl_pkg::GAIN_DB_11;
    endcase
    return db;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  localparam int SW = $bits(afl_pkg::afl_fault_s) + $bits(afl_pkg::afl_ctl_s);

  afl_pkg::afl_fault_s flt_raw;
  afl_pkg::afl_fault_s flt;
  afl_pkg::afl_ctl_s   ctl_raw;
  afl_pkg::afl_ctl_s   ctl;

  assign flt_raw = '{clk_missing:    clk_missing,
                     supply_uv:      supply_uv,
                     over_current:   over_current,
                     temp_shut:      temp_shut,
                     temp_cool:      temp_cool,
                     temp_warn_trip: temp_warn_trip};
  assign ctl_raw = '{power_down_n: power_down_n,
                     mute_n:       mute_n,
                     gain_sel_msb: gain_sel_msb,
                     gain_sel_lsb: gain_sel_lsb};

  afl_sync #(
    .W (SW)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      ({flt_raw, ctl_raw}),
    .q      ({flt, ctl})
  ); // RULE_16

  ////////////////////////////////////////////////////////////////////////////
  // Internal mute timer

  logic int_done;

  afl_mute_timer #(
    .TICKS (INT_MUTE_TICKS)
  ) u_timer (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .run       (ctl.power_down_n),
    .mclk_tick (),
    .done      (int_done)
  ); // RULE_15

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] next_prdata;
  logic [31:0] status;
  logic        hit_ctrl;
  logic        hit_status;
  logic        wr_en;
  logic        sw_clear;
  logic        soft_mute;

  assign hit_ctrl   = paddr == afl_pkg::OFS_CTRL;
  assign hit_status = paddr == afl_pkg::OFS_STATUS;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !(hit_ctrl || hit_status);
  assign wr_en      = psel && penable && pwrite && hit_ctrl;
  assign soft_mute  = ctrl[afl_pkg::CTRL_SOFT_MUTE_BIT];
  assign sw_clear   = ce && wr_en && pwdata[afl_pkg::CTRL_ERR_CLEAR_BIT];

  always_comb begin
    next_ctrl   = ctrl;
    next_prdata = prdata;
    if (ce) begin
      if (wr_en) begin
        next_ctrl = 32'h0000_0000;
        next_ctrl[afl_pkg::CTRL_SOFT_MUTE_BIT] = pwdata[afl_pkg::CTRL_SOFT_MUTE_BIT];
      end
      if (psel && !penable && !pwrite) begin
        next_prdata = hit_ctrl ? ctrl : (hit_status ? status : 32'h0000_0000);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl   <= afl_pkg::CTRL_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl   <= next_ctrl;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal warning with hysteresis

  logic warn;
  logic next_warn;

  always_comb begin
    next_warn = warn;
    if (ce) begin
      next_warn = flt.temp_warn_trip || (warn && !flt.temp_cool); // RULE_02 RULE_10
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warn <= 1'b0;
    end else begin
      warn <= next_warn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error latches and mute clearing sequence

  afl_pkg::afl_err_t err;
  afl_pkg::afl_err_t next_err;
  afl_pkg::afl_err_t err_set;
  logic              seen_low;
  logic              next_seen_low;
  logic              mute_clear;
  logic              any_err;

  assign mute_clear = seen_low && ctl.mute_n; // RULE_05
  assign any_err    = |err;

  always_comb begin
    err_set = '0;
    err_set[afl_pkg::ERR_TEMP]      = flt.temp_shut;    // RULE_04
    err_set[afl_pkg::ERR_OVERCUR]   = flt.over_current; // RULE_06
    err_set[afl_pkg::ERR_UNDERVOLT] = flt.supply_uv;    // RULE_07
    err_set[afl_pkg::ERR_CLK_LOSS]  = flt.clk_missing;  // RULE_08
    next_err      = err;
    next_seen_low = seen_low;
    if (ce) begin
      // A fault still present wins over the clear
      next_err      = err_set | ((mute_clear || sw_clear) ? '0 : err); // RULE_05
      next_seen_low = !ctl.mute_n || (seen_low && !mute_clear);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err      <= '0;
      seen_low <= 1'b0;
    end else begin
      err      <= next_err;
      seen_low <= next_seen_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage state machine

  afl_pkg::afl_state_e state;
  afl_pkg::afl_state_e next_state;
  logic                unmute_ok;

  // Warning is not a stop condition
  assign unmute_ok = ctl.mute_n && !soft_mute && int_done && !flt.supply_uv; // RULE_03 RULE_11 RULE_15

  always_comb begin
    next_state = state;
    if (ce) begin
      if (!ctl.power_down_n) begin
        next_state = afl_pkg::ST_OFF; // RULE_13
      end else begin
        case (state)
          afl_pkg::ST_OFF: begin
            next_state = afl_pkg::ST_MUTED; // RULE_13
          end
          afl_pkg::ST_MUTED: begin
            if (any_err || err_set != '0) begin
              next_state = afl_pkg::ST_FAULT; // RULE_17
            end else if (unmute_ok) begin
              next_state = afl_pkg::ST_RUN; // RULE_12
            end
          end
          afl_pkg::ST_RUN: begin
            if (any_err || err_set != '0) begin
              next_state = afl_pkg::ST_FAULT; // RULE_06 RULE_07 RULE_17
            end else if (!unmute_ok) begin
              next_state = afl_pkg::ST_MUTED; // RULE_11
            end
          end
          afl_pkg::ST_FAULT: begin
            if (!any_err && err_set == '0) begin
              next_state = afl_pkg::ST_MUTED;
            end
          end
          default: begin
            next_state = afl_pkg::ST_OFF;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= afl_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [1:0] next_gain_code;
  logic [4:0] next_gain_db;
  logic       next_mod_en;
  logic       next_stage_en;

  always_comb begin
    next_gain_code = gain_code;
    next_gain_db   = gain_db;
    next_mod_en    = modulator_en;
    next_stage_en  = stage_en;
    if (ce) begin
      next_gain_code = {ctl.gain_sel_msb, ctl.gain_sel_lsb};                 // RULE_01
      next_gain_db   = code_to_db({ctl.gain_sel_msb, ctl.gain_sel_lsb});     // RULE_01
      next_mod_en    = ctl.power_down_n;                                     // RULE_13
      next_stage_en  = next_state == afl_pkg::ST_RUN && !any_err && !flt.supply_uv; // RULE_17 RULE_07
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_code    <= 2'h0;
      gain_db      <= afl_pkg::GAIN_DB_00;
      modulator_en <= 1'b0;
      stage_en     <= 1'b0;
    end else begin
      gain_code    <= next_gain_code;
      gain_db      <= next_gain_db;
      modulator_en <= next_mod_en;
      stage_en     <= next_stage_en;
    end
  end

  assign stage_hiz = !stage_en; // RULE_07 RULE_13

  // Flags only sink or release
  assign thermal_warn_n_o    = 1'b0;   // RULE_09
  assign thermal_warn_n_oe_n = !warn;  // RULE_02 RULE_09
  assign error_n_o           = 1'b0;   // RULE_09
  assign error_n_oe_n        = !any_err; // RULE_04 RULE_09

  always_comb begin
    status = 32'h0000_0000;
    status[afl_pkg::STAT_ERR_LSB +: afl_pkg::ERR_NUM] = err;
    status[afl_pkg::STAT_WARN_BIT]      = warn;
    status[afl_pkg::STAT_STAGE_EN_BIT]  = stage_en;
    status[afl_pkg::STAT_INT_DONE_BIT]  = int_done;
    status[afl_pkg::STAT_MOD_EN_BIT]    = modulator_en;
    status[afl_pkg::STAT_GAIN_LSB +: 2] = gain_code;
    status[afl_pkg::STAT_PIN_ERR_BIT]   = error_n_i;
    status[afl_pkg::STAT_PIN_WARN_BIT]  = thermal_warn_n_i;
    status[afl_pkg::STAT_STATE_LSB +: 2] = state;
  end

endmodule

// *** sim/afl_checker.sv ***
// Purpose: Port-level timing checks for the fault latch block
// Assumes: One clock domain, ce held high while checked
// Notes:   Sync latency is three edges from pin to flag
`timescale 1ns/1ns
module afl_checker #(
  parameter int INT_MUTE_TICKS = 8
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Bus strobes
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  // Control pins and detectors
  input  wire logic       mute_n,
  input  wire logic       power_down_n,
  input  wire logic       gain_sel_msb,
  input  wire logic       gain_sel_lsb,
  input  wire logic       temp_warn_trip,
  input  wire logic       temp_cool,
  input  wire logic       temp_shut,
  input  wire logic       over_current,
  input  wire logic       supply_uv,
  input  wire logic       clk_missing,
  // Flags and stage
  input  wire logic       thermal_warn_n_o,
  input  wire logic       thermal_warn_n_oe_n,
  input  wire logic       error_n_o,
  input  wire logic       error_n_oe_n,
  input  wire logic       modulator_en,
  input  wire logic       stage_en,
  input  wire logic       stage_hiz,
  input  wire logic [1:0] gain_code,
  input  wire logic [4:0] gain_db
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  wire logic any_err = temp_shut | over_current | supply_uv | clk_missing;
  int        mute_cnt;

  // Cycles since the modulator woke, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mute_cnt <= 0;
    end else if (!modulator_en) begin
      mute_cnt <= 0;
    end else if (mute_cnt < 2 * INT_MUTE_TICKS) begin
      mute_cnt <= mute_cnt + 1;
    end
  end

  // Latched error with mute high and no bus write
  sequence s_err_idle;
    (!error_n_oe_n && mute_n && !(psel && penable && pwrite))[*6];
  endsequence

  chk_gain_pins: assert property ($stable({gain_sel_msb, gain_sel_lsb})[*5] |=>
    gain_code == $past({gain_sel_msb, gain_sel_lsb}) &&
    gain_db == {1'b0, gain_code, 2'b00} + {2'b00, gain_code, 1'b0}) else $error("gain mismatch");
  chk_warn_set: assert property (temp_warn_trip[*4] |=> !thermal_warn_n_oe_n)
    else $error("warning flag not driven");
  chk_warn_release: assert property ($rose(thermal_warn_n_oe_n) |-> $past(temp_cool, 3))
    else $error("warning released while hot");
  chk_err_set: assert property (any_err[*3] |=> !error_n_oe_n)
    else $error("error flag not latched");
  chk_err_sync: assert property ($fell(error_n_oe_n) |-> $past(any_err, 3))
    else $error("error flag set too early");
  chk_err_hold: assert property (s_err_idle |=> !error_n_oe_n)
    else $error("error flag cleared without mute toggle");
  chk_err_stage_off: assert property (!error_n_oe_n |-> !stage_en && stage_hiz)
    else $error("stage on with error latched");
  chk_mute_stage: assert property (!mute_n[*5] |=> !stage_en)
    else $error("stage on while muted");
  chk_pdown_off: assert property (!power_down_n[*5] |=> !modulator_en && stage_hiz)
    else $error("modulator on in power down");
  chk_int_mute: assert property ($rose(modulator_en) |-> !stage_en[*8])
    else $error("stage on during internal mute");
  chk_int_mute_len: assert property ($rose(stage_en) |-> mute_cnt >= 2 * INT_MUTE_TICKS - 1)
    else $error("stage on before internal mute ended");
  chk_flags_sink: assert property (!thermal_warn_n_o && !error_n_o)
    else $error("flag pin driven high");
endmodule

bind afl_top afl_checker #(.INT_MUTE_TICKS(INT_MUTE_TICKS)) u_afl_checker (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .mute_n(mute_n),
  .power_down_n(power_down_n), .gain_sel_msb(gain_sel_msb), .gain_sel_lsb(gain_sel_lsb),
  .temp_warn_trip(temp_warn_trip), .temp_cool(temp_cool), .temp_shut(temp_shut),
  .over_current(over_current), .supply_uv(supply_uv), .clk_missing(clk_missing),
  .thermal_warn_n_o(thermal_warn_n_o), .thermal_warn_n_oe_n(thermal_warn_n_oe_n),
  .error_n_o(error_n_o), .error_n_oe_n(error_n_oe_n), .modulator_en(modulator_en),
  .stage_en(stage_en), .stage_hiz(stage_hiz), .gain_code(gain_code), .gain_db(gain_db));

// *** sim/afl_host_model.sv ***
// Purpose: System controller on the control pins and flag lines
// Assumes: Flag lines carry pull-ups to the logic supply
// Notes:   Pins change only just after a rising edge
`timescale 1ns/1ns
module afl_host_model (
  // Clock
  input  wire logic clk,
  // Flag drivers from the amplifier
  input  wire logic thermal_warn_n_o,
  input  wire logic thermal_warn_n_oe_n,
  input  wire logic error_n_o,
  input  wire logic error_n_oe_n,
  // Resolved flag lines
  output logic      thermal_warn_n_i,
  output logic      error_n_i,
  // Control pins
  output logic      mute_n,
  output logic      power_down_n,
  output logic      gain_sel_msb,
  output logic      gain_sel_lsb
);
  // Pulled-up lines, only sunk low
  assign thermal_warn_n_i = thermal_warn_n_oe_n ? 1'b1 : thermal_warn_n_o;
  assign error_n_i        = error_n_oe_n ? 1'b1 : error_n_o;

  initial begin
    mute_n       = 1'b0;
    power_down_n = 1'b0;
    gain_sel_msb = 1'b0;
    gain_sel_lsb = 1'b0;
  end

  task automatic set_pins(input logic m, input logic p, input logic [1:0] g);
    @(posedge clk);
    mute_n                       <= m;
    power_down_n                 <= p;
    {gain_sel_msb, gain_sel_lsb} <= g;
  endtask

  // Low-then-high on mute to release a latched error
  task automatic clear_error(input int low_cycles);
    set_pins(1'b0, power_down_n, {gain_sel_msb, gain_sel_lsb});
    repeat (low_cycles) @(posedge clk);
    set_pins(1'b1, power_down_n, {gain_sel_msb, gain_sel_lsb});
  endtask
endmodule

// *** sim/test_amp_fault_latch_control.sv ***
// Purpose: Scenario bench for the fault latch block
// Assumes: Internal mute shortened to 8 master ticks
// Notes:   ce held high throughout
`timescale 1ns/1ns
module test_amp_fault_latch_control;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready, pslverr, warn_o, warn_oe_n, err_o, err_oe_n, warn_i, err_i;
  logic                mute_n, power_down_n, gain_sel_msb, gain_sel_lsb;
  logic                modulator_en, stage_en, stage_hiz;
  logic [1:0]          gain_code;
  logic [4:0]          gain_db;
  afl_pkg::afl_fault_s flt = '0;
  int                  n_fail = 0;
  int                  checked = 0;

  always #20 clk = ~clk;

  afl_top #(.INT_MUTE_TICKS(8)) u_afl_top (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mute_n(mute_n), .power_down_n(power_down_n), .gain_sel_msb(gain_sel_msb),
    .gain_sel_lsb(gain_sel_lsb), .temp_warn_trip(flt.temp_warn_trip), .temp_cool(flt.temp_cool),
    .temp_shut(flt.temp_shut), .over_current(flt.over_current), .supply_uv(flt.supply_uv),
    .clk_missing(flt.clk_missing), .thermal_warn_n_i(warn_i), .thermal_warn_n_o(warn_o),
    .thermal_warn_n_oe_n(warn_oe_n), .error_n_i(err_i), .error_n_o(err_o), .error_n_oe_n(err_oe_n),
    .modulator_en(modulator_en), .stage_en(stage_en), .stage_hiz(stage_hiz),
    .gain_code(gain_code), .gain_db(gain_db));

  afl_host_model u_afl_host_model (
    .clk(clk), .thermal_warn_n_o(warn_o),
    .thermal_warn_n_oe_n(warn_oe_n), .error_n_o(err_o), .error_n_oe_n(err_oe_n),
    .thermal_warn_n_i(warn_i), .error_n_i(err_i), .mute_n(mute_n), .power_down_n(power_down_n),
    .gain_sel_msb(gain_sel_msb), .gain_sel_lsb(gain_sel_lsb));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_stage(input logic exp, output int n);
    for (n = 0; n < 200 && stage_en !== exp; n++)
      tick(1);
    if (n == 200) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      n_fail++;
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs_gain();
    logic [31:0] rd;
    logic        e;
    apb(1'b0, afl_pkg::OFS_CTRL, 32'h0, rd, e);
    check("ctrl_reset", rd, afl_pkg::CTRL_RESET);
    apb(1'b0, 12'h008, 32'h0, rd, e);
    check("unmapped_err", {31'h0, e}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      u_afl_host_model.set_pins(1'b0, 1'b0, k[1:0]);
      tick(6);
      check("gain_code", {30'h0, gain_code}, 32'(k));
      check("gain_db", {27'h0, gain_db}, 32'(6 * k));
    end
    check("mod_off", {31'h0, modulator_en}, 32'h0);
    check("hiz_off", {31'h0, stage_hiz}, 32'h1);
  endtask

  task automatic t_powerup();
    int n;
    u_afl_host_model.set_pins(1'b1, 1'b1, 2'b11);
    tick(6);
    check("mod_on", {31'h0, modulator_en}, 32'h1);
    check("early_hiz", {31'h0, stage_hiz}, 32'h1);
    wait_stage(1'b1, n);
    check("int_mute_len", {31'h0, 6 + n >= 16}, 32'h1);
  endtask

  task automatic t_warn();
    @(posedge clk);
    flt.temp_warn_trip <= 1'b1;
    tick(5);
    check("warn_low", {31'h0, warn_i}, 32'h0);
    check("warn_runs", {31'h0, stage_en}, 32'h1);
    @(posedge clk);
    flt.temp_warn_trip <= 1'b0;
    tick(8);
    check("warn_hyst", {31'h0, warn_i}, 32'h0);
    @(posedge clk);
    flt.temp_cool <= 1'b1;
    tick(5);
    check("warn_free", {31'h0, warn_i}, 32'h1);
    @(posedge clk);
    flt.temp_cool <= 1'b0;
  endtask

  task automatic t_fault(input int i);
    logic [31:0] rd;
    logic        e;
    int          n;
    @(posedge clk);
    flt[2+i] <= 1'b1;
    repeat (3) @(posedge clk);
    flt[2+i] <= 1'b0;
    tick(3);
    check("err_low", {31'h0, err_i}, 32'h0);
    check("err_stage", {31'h0, stage_hiz}, 32'h1);
    apb(1'b0, afl_pkg::OFS_STATUS, 32'h0, rd, e);
    check("err_latch", {28'h0, rd[3:0]}, 32'h1 << i);
    tick(10);
    check("err_held", {31'h0, err_i}, 32'h0);
    if (i == afl_pkg::ERR_CLK_LOSS)
      apb(1'b1, afl_pkg::OFS_CTRL, 32'h2, rd, e);
    else
      u_afl_host_model.clear_error(4);
    tick(8);
    check("err_clear", {31'h0, err_i}, 32'h1);
    wait_stage(1'b1, n);
  endtask

  task automatic t_mute_ctrl();
    logic [31:0] rd;
    logic        e;
    int          n;
    u_afl_host_model.set_pins(1'b0, 1'b1, 2'b11);
    tick(6);
    check("mute_off", {31'h0, stage_en}, 32'h0);
    u_afl_host_model.set_pins(1'b1, 1'b1, 2'b11);
    wait_stage(1'b1, n);
    apb(1'b1, afl_pkg::OFS_CTRL, 32'h1, rd, e);
    apb(1'b0, afl_pkg::OFS_CTRL, 32'h0, rd, e);
    check("ctrl_rd", rd, 32'h1);
    wait_stage(1'b0, n);
    apb(1'b1, afl_pkg::OFS_CTRL, 32'h0, rd, e);
    wait_stage(1'b1, n);
    apb(1'b0, afl_pkg::OFS_STATUS, 32'h0, rd, e);
    check("stat_run", {18'h0, rd[13:12], 4'h0, rd[7], 1'b0, rd[5], 5'h0}, 32'h30a0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_regs_gain();
    t_powerup();
    t_warn();
    for (int i = 0; i < afl_pkg::ERR_NUM; i++)
      t_fault(i);
    t_mute_ctrl();
    give_verdict();
  end
endmodule
